// ===== logic/tmf_flags.sv
// Interrupt enable, event flags and input capture of a 16-bit free-running timer
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tmf_flags
  import tmf_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              standby,
  input  wire logic [15:0]       running_counter,
  input  wire logic              counter_tick,
  input  wire logic [15:0]       compare_a_value,
  input  wire logic [15:0]       compare_b_value,
  input  wire logic              cap_a_pin,
  input  wire logic              cap_b_pin,
  input  wire logic              cap_c_pin,
  input  wire logic              cap_d_pin,
  output logic                   counter_clear,
  output logic                   cap_a_irq,
  output logic                   cap_b_irq,
  output logic                   cap_c_irq,
  output logic                   cap_d_irq,
  output logic                   cmp_a_irq,
  output logic                   cmp_b_irq,
  output logic                   counter_wrap_irq,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic edge_hit(input logic prev, input logic cur, input logic rising);
    edge_hit = rising ? (!prev && cur) : (prev && !cur);
  endfunction

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    addr_is = (a[ADDR_W-1:2] == r[ADDR_W-1:2]);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  timer_irq_enable;
  logic [7:0]  timer_flag_status;
  logic [7:0]  timer_control;
  logic [7:0]  armed;
  logic [15:0] capture_a_value;
  logic [15:0] capture_b_value;
  logic [15:0] capture_c_value;
  logic [15:0] capture_d_value;
  logic [3:0]  pin_prev;
  logic [7:0]  next_timer_irq_enable;
  logic [7:0]  next_timer_flag_status;
  logic [7:0]  next_timer_control;
  logic [7:0]  next_armed;
  logic [15:0] next_capture_a_value;
  logic [15:0] next_capture_b_value;
  logic [15:0] next_capture_c_value;
  logic [15:0] next_capture_d_value;
  logic [3:0]  next_pin_prev;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        next_rvalid;
  logic [1:0]  next_bresp;
  logic        next_bvalid;

  logic       wr_fire;
  logic       rd_fire;
  logic       wr_low;
  logic       ev_a;
  logic       ev_b;
  logic       ev_c;
  logic       ev_d;
  logic       match_a;
  logic       match_b;
  logic       wrap_ev;
  logic       buf_a;
  logic       buf_b;
  logic [7:0] set_ev;

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  assign buf_a   = timer_control[BIT_BUFFER_A];
  assign buf_b   = timer_control[BIT_BUFFER_B];
  // In buffer mode the paired pin's edge select adds a second trigger edge
  assign ev_a    = edge_hit(pin_prev[3], cap_a_pin, timer_control[BIT_EDGE_A])
                 || (buf_a && edge_hit(pin_prev[3], cap_a_pin, timer_control[BIT_EDGE_C]));
  assign ev_b    = edge_hit(pin_prev[2], cap_b_pin, timer_control[BIT_EDGE_B])
                 || (buf_b && edge_hit(pin_prev[2], cap_b_pin, timer_control[BIT_EDGE_D]));
  assign ev_c    = edge_hit(pin_prev[1], cap_c_pin, timer_control[BIT_EDGE_C]);
  assign ev_d    = edge_hit(pin_prev[0], cap_d_pin, timer_control[BIT_EDGE_D]);
  assign match_a = (running_counter == compare_a_value);
  assign match_b = (running_counter == compare_b_value);
  assign wrap_ev = counter_tick && (running_counter == COUNTER_MAX);
  assign set_ev  = {ev_a, ev_b, ev_c, ev_d, match_a, match_b, wrap_ev, 1'b0};

  assign counter_clear = timer_flag_status[BIT_CLEAR_CMPA] && match_a;

  // Request levels
  assign cap_a_irq        = timer_flag_status[BIT_CAP_A] && timer_irq_enable[BIT_CAP_A];
  assign cap_b_irq        = timer_flag_status[BIT_CAP_B] && timer_irq_enable[BIT_CAP_B];
  assign cap_c_irq        = timer_flag_status[BIT_CAP_C] && timer_irq_enable[BIT_CAP_C];
  assign cap_d_irq        = timer_flag_status[BIT_CAP_D] && timer_irq_enable[BIT_CAP_D];
  assign cmp_a_irq        = timer_flag_status[BIT_CMP_A] && timer_irq_enable[BIT_CMP_A];
  assign cmp_b_irq        = timer_flag_status[BIT_CMP_B] && timer_irq_enable[BIT_CMP_B];
  assign counter_wrap_irq = timer_flag_status[BIT_WRAP] && timer_irq_enable[BIT_WRAP];

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && !s_axi_rvalid;
  assign wr_low        = wr_fire && s_axi_wstrb[0];

  // ----------------------------------------------------------------
  // Timer registers
  // ----------------------------------------------------------------
  always_comb begin
    next_timer_irq_enable  = timer_irq_enable;
    next_timer_flag_status = timer_flag_status;
    next_timer_control     = timer_control;
    next_armed             = armed;
    next_capture_a_value   = capture_a_value;
    next_capture_b_value   = capture_b_value;
    next_capture_c_value   = capture_c_value;
    next_capture_d_value   = capture_d_value;
    next_pin_prev          = {cap_a_pin, cap_b_pin, cap_c_pin, cap_d_pin};
    if (wr_low && addr_is(s_axi_awaddr, ADDR_IRQ_ENABLE)) begin
      next_timer_irq_enable = s_axi_wdata[7:0];
    end
    next_timer_irq_enable[BIT_RESERVED] = 1'b1;
    if (wr_low && addr_is(s_axi_awaddr, ADDR_TIMER_CONTROL)) begin
      next_timer_control = s_axi_wdata[7:0];
    end
    if (wr_low && addr_is(s_axi_awaddr, ADDR_FLAG_STATUS)) begin
      next_timer_flag_status[BIT_CLEAR_CMPA] = s_axi_wdata[BIT_CLEAR_CMPA];
    end
    for (int i = 1; i < 8; i++) begin
      // A zero write clears only a flag that was read as one beforehand
      if (wr_low && addr_is(s_axi_awaddr, ADDR_FLAG_STATUS) && !s_axi_wdata[i] && armed[i]) begin
        next_timer_flag_status[i] = 1'b0;
      end
      if (set_ev[i]) begin
        next_timer_flag_status[i] = 1'b1;
      end
      if (rd_fire && addr_is(s_axi_araddr, ADDR_FLAG_STATUS) && timer_flag_status[i]) begin
        next_armed[i] = 1'b1;
      end
      if (!next_timer_flag_status[i]) begin
        next_armed[i] = 1'b0;
      end
    end
    next_armed[0] = 1'b0;
    // Capture regardless of the flag's state
    if (ev_a) begin
      next_capture_a_value = running_counter;
      if (buf_a) begin
        next_capture_c_value = capture_a_value;
      end
    end
    if (ev_b) begin
      next_capture_b_value = running_counter;
      if (buf_b) begin
        next_capture_d_value = capture_b_value;
      end
    end
    if (ev_c && !buf_a) begin
      next_capture_c_value = running_counter;
    end
    if (ev_d && !buf_b) begin
      next_capture_d_value = running_counter;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      timer_irq_enable  <= IRQ_ENABLE_RST;
      timer_flag_status <= FLAG_STATUS_RST;
      timer_control     <= TIMER_CONTROL_RST;
      armed             <= FLAG_STATUS_RST;
      capture_a_value   <= CAPTURE_RST;
      capture_b_value   <= CAPTURE_RST;
      capture_c_value   <= CAPTURE_RST;
      capture_d_value   <= CAPTURE_RST;
      pin_prev          <= 4'h0;
    end else begin
      timer_irq_enable  <= next_timer_irq_enable;
      timer_flag_status <= next_timer_flag_status;
      timer_control     <= next_timer_control;
      armed             <= next_armed;
      capture_a_value   <= next_capture_a_value;
      capture_b_value   <= next_capture_b_value;
      capture_c_value   <= next_capture_c_value;
      capture_d_value   <= next_capture_d_value;
      pin_prev          <= next_pin_prev;
    end
  end

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_bresp  = s_axi_bresp;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      if (addr_is(s_axi_araddr, ADDR_IRQ_ENABLE)) begin
        next_rdata = {24'h000000, timer_irq_enable};
      end else if (addr_is(s_axi_araddr, ADDR_FLAG_STATUS)) begin
        next_rdata = {24'h000000, timer_flag_status};
      end else if (addr_is(s_axi_araddr, ADDR_TIMER_CONTROL)) begin
        next_rdata = {24'h000000, timer_control};
      end else if (addr_is(s_axi_araddr, ADDR_CAPTURE_A)) begin
        next_rdata = {16'h0000, capture_a_value};
      end else if (addr_is(s_axi_araddr, ADDR_CAPTURE_B)) begin
        next_rdata = {16'h0000, capture_b_value};
      end else if (addr_is(s_axi_araddr, ADDR_CAPTURE_C)) begin
        next_rdata = {16'h0000, capture_c_value};
      end else if (addr_is(s_axi_araddr, ADDR_CAPTURE_D)) begin
        next_rdata = {16'h0000, capture_d_value};
      end else begin
        next_rdata = 32'h00000000;
        next_rresp = RESP_SLVERR;
      end
    end
    if (wr_fire) begin
      next_bvalid = 1'b1;
      if (addr_is(s_axi_awaddr, ADDR_IRQ_ENABLE) || addr_is(s_axi_awaddr, ADDR_FLAG_STATUS)
          || addr_is(s_axi_awaddr, ADDR_TIMER_CONTROL) || addr_is(s_axi_awaddr, ADDR_CAPTURE_A)
          || addr_is(s_axi_awaddr, ADDR_CAPTURE_B) || addr_is(s_axi_awaddr, ADDR_CAPTURE_C)
          || addr_is(s_axi_awaddr, ADDR_CAPTURE_D)) begin
        next_bresp = RESP_OKAY;
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_bvalid <= 1'b0;
    end else begin
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_bvalid <= next_bvalid;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_standby_reinit: assert property (
    standby |=> timer_irq_enable == IRQ_ENABLE_RST && timer_flag_status == FLAG_STATUS_RST)
    else $error("standby did not reinitialise enable and status");
  chk_reserved_one: assert property (
    s_axi_rvalid && !$past(s_axi_rvalid) && $past(addr_is(s_axi_araddr, ADDR_IRQ_ENABLE))
    |-> s_axi_rdata[0])
    else $error("reserved enable bit read back as zero");
  chk_cap_a_request: assert property (
    $rose(timer_flag_status[BIT_CAP_A]) && timer_irq_enable[BIT_CAP_A] |-> cap_a_irq)
    else $error("capture A request missing");
  chk_cmp_b_gate: assert property (
    !timer_irq_enable[BIT_CMP_B] |-> !cmp_b_irq)
    else $error("compare B request with enable off");
  chk_wrap_request: assert property (
    wrap_ev && timer_irq_enable[BIT_WRAP] && !standby
    && !(wr_low && addr_is(s_axi_awaddr, ADDR_IRQ_ENABLE)) |=> counter_wrap_irq)
    else $error("wrap request missing after wrap");
  chk_no_soft_set: assert property (
    wr_low && addr_is(s_axi_awaddr, ADDR_FLAG_STATUS) && s_axi_wdata[BIT_CMP_A]
    && !timer_flag_status[BIT_CMP_A] && !match_a |=> !timer_flag_status[BIT_CMP_A])
    else $error("software set a compare flag");
  chk_clear_needs_read: assert property (
    timer_flag_status[BIT_CMP_B] && !armed[BIT_CMP_B] && !standby |=> timer_flag_status[BIT_CMP_B])
    else $error("flag cleared without a prior read");
  chk_capture_a_plain: assert property (
    ev_a && !buf_a && !standby |=> capture_a_value == $past(running_counter))
    else $error("capture A missed counter value");
  chk_buffer_c_shift: assert property (
    ev_a && buf_a && !standby |=> capture_c_value == $past(capture_a_value)
    && capture_a_value == $past(running_counter))
    else $error("capture A buffer shift into C failed");
  chk_cmp_a_flag: assert property (
    match_a && !standby |=> timer_flag_status[BIT_CMP_A] [*1])
    else $error("compare A flag not set on match");
  chk_wrap_flag: assert property (
    wrap_ev && !standby |=> timer_flag_status[BIT_WRAP])
    else $error("wrap flag not set");
  chk_counter_clear: assert property (
    timer_flag_status[BIT_CLEAR_CMPA] && running_counter == compare_a_value |-> counter_clear)
    else $error("counter clear missing on compare A");
  chk_bus_answer: assert property (
    wr_fire |=> s_axi_bvalid)
    else $error("write answer did not follow");

endmodule

// ===== shared/tmf_pkg.sv
// Register map, field positions and reset values of the timer flag block
package tmf_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam int          ADDR_W            = 18;
  localparam logic [15:0] IDX_IRQ_ENABLE    = 16'hFF90;
  localparam logic [15:0] IDX_FLAG_STATUS   = 16'hFF91;
  localparam logic [15:0] IDX_TIMER_CONTROL = 16'hFF96;
  localparam logic [15:0] IDX_CAPTURE_A     = 16'hFF98;
  localparam logic [15:0] IDX_CAPTURE_B     = 16'hFF9A;
  localparam logic [15:0] IDX_CAPTURE_C     = 16'hFF9C;
  localparam logic [15:0] IDX_CAPTURE_D     = 16'hFF9E;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE    = {IDX_IRQ_ENABLE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_FLAG_STATUS   = {IDX_FLAG_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_TIMER_CONTROL = {IDX_TIMER_CONTROL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CAPTURE_A     = {IDX_CAPTURE_A, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CAPTURE_B     = {IDX_CAPTURE_B, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CAPTURE_C     = {IDX_CAPTURE_C, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CAPTURE_D     = {IDX_CAPTURE_D, 2'h0};

  // ----------------------------------------------------------------
  // Reset values and counter maximum
  // ----------------------------------------------------------------
  localparam logic [7:0]  IRQ_ENABLE_RST    = 8'h01;
  localparam logic [7:0]  FLAG_STATUS_RST   = 8'h00;
  localparam logic [7:0]  TIMER_CONTROL_RST = 8'h00;
  localparam logic [15:0] CAPTURE_RST       = 16'h0000;
  localparam logic [15:0] COUNTER_MAX       = 16'hFFFF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_CAP_A      = 7;
  localparam int BIT_CAP_B      = 6;
  localparam int BIT_CAP_C      = 5;
  localparam int BIT_CAP_D      = 4;
  localparam int BIT_CMP_A      = 3;
  localparam int BIT_CMP_B      = 2;
  localparam int BIT_WRAP       = 1;
  localparam int BIT_CLEAR_CMPA = 0;
  localparam int BIT_RESERVED   = 0;
  localparam int BIT_EDGE_A     = 7;
  localparam int BIT_EDGE_B     = 6;
  localparam int BIT_EDGE_C     = 5;
  localparam int BIT_EDGE_D     = 4;
  localparam int BIT_BUFFER_A   = 3;
  localparam int BIT_BUFFER_B   = 2;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== verification/timer_irq_enable_and_flags_tb.sv
// Self-checking testbench of the timer interrupt enable and flag block
`timescale 1ns/1ps
module timer_irq_enable_and_flags_tb
  import tmf_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic              aclk, aresetn, standby, counter_tick, counter_clear;
  logic              cap_a_pin, cap_b_pin, cap_c_pin, cap_d_pin;
  logic [15:0]       running_counter, compare_a_value, compare_b_value;
  logic              cap_a_irq, cap_b_irq, cap_c_irq, cap_d_irq;
  logic              cmp_a_irq, cmp_b_irq, counter_wrap_irq;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic [6:0]        irqs;
  int                err_total, comparisons;

  assign irqs = {cap_a_irq, cap_b_irq, cap_c_irq, cap_d_irq, cmp_a_irq, cmp_b_irq,
                 counter_wrap_irq};

  always #50 aclk = ~aclk;

  tmf_flags DUT (
    .aclk, .aresetn, .standby, .running_counter, .counter_tick, .compare_a_value,
    .compare_b_value, .cap_a_pin, .cap_b_pin, .cap_c_pin, .cap_d_pin, .counter_clear,
    .cap_a_irq, .cap_b_irq, .cap_c_irq, .cap_d_irq, .cmp_a_irq, .cmp_b_irq, .counter_wrap_irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  tmf_cpu_model cpu (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (cpu.timed_out) err_total++;
    $display("Totals: %0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      err_total++;
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [1:0] r;
    cpu.wr(a, d, r);
    if (cpu.timed_out) finish_test();
    chk({r, 32'h0}, {RESP_OKAY, 32'h0}, "write response");
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    cpu.rd(a, d, r);
    if (cpu.timed_out) finish_test();
    chk({r, d}, {RESP_OKAY, e}, what);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(ADDR_IRQ_ENABLE, 32'h01, "enable reset");
    rd_chk(ADDR_FLAG_STATUS, 32'h00, "status reset");
    cpu.rd(18'h00010, d, r);
    chk({r, d}, {RESP_SLVERR, 32'h0}, "unmapped read");
    wr(ADDR_IRQ_ENABLE, 32'hFE);
    rd_chk(ADDR_IRQ_ENABLE, 32'hFF, "enable all");
    wr(ADDR_IRQ_ENABLE, 32'h00);
    rd_chk(ADDR_IRQ_ENABLE, 32'h01, "enable bit0 fixed");
    wr(ADDR_FLAG_STATUS, 32'hFE);
    rd_chk(ADDR_FLAG_STATUS, 32'h00, "flags not set by write");
    $display("Test registers done");
  endtask

  task automatic t_capture();
    running_counter <= 16'h1234;
    wr(ADDR_TIMER_CONTROL, 32'h80);
    cap_a_pin <= 1'b1;
    step(2);
    rd_chk(ADDR_FLAG_STATUS, 32'h80, "cap A flag");
    rd_chk(ADDR_CAPTURE_A, 32'h1234, "cap A value");
    cap_a_pin <= 1'b0;
    running_counter <= 16'h2222;
    step(2);
    cap_a_pin <= 1'b1;
    step(2);
    rd_chk(ADDR_CAPTURE_A, 32'h2222, "capture with flag set");
    cap_b_pin <= 1'b1;
    step(2);
    rd_chk(ADDR_FLAG_STATUS, 32'h80, "rising B ignored");
    cap_b_pin <= 1'b0;
    step(2);
    rd_chk(ADDR_FLAG_STATUS, 32'hC0, "cap B flag");
    rd_chk(ADDR_CAPTURE_B, 32'h2222, "cap B value");
    $display("Test capture done");
  endtask

  task automatic t_clear();
    wr(ADDR_IRQ_ENABLE, 32'h00);
    chk({27'h0, irqs}, {27'h0, 7'b0000000}, "masked requests");
    wr(ADDR_IRQ_ENABLE, 32'hFE);
    chk({27'h0, irqs}, {27'h0, 7'b1100000}, "capture requests");
    running_counter <= 16'hFFFF;
    counter_tick <= 1'b1;
    step(1);
    counter_tick <= 1'b0;
    running_counter <= 16'h0000;
    step(2);
    wr(ADDR_FLAG_STATUS, 32'h00);
    rd_chk(ADDR_FLAG_STATUS, 32'h02, "unread wrap flag kept");
    chk({27'h0, irqs}, {27'h0, 7'b0000001}, "wrap request");
    wr(ADDR_FLAG_STATUS, 32'h00);
    rd_chk(ADDR_FLAG_STATUS, 32'h00, "wrap flag cleared");
    chk({27'h0, irqs}, {27'h0, 7'b0000000}, "requests dropped");
    $display("Test clear done");
  endtask

  task automatic t_compare();
    wr(ADDR_FLAG_STATUS, 32'h01);
    running_counter <= 16'h0100;
    step(1);
    chk({33'h0, counter_clear}, {33'h0, 1'b1}, "clear on match A");
    running_counter <= 16'h0200;
    step(1);
    chk({33'h0, counter_clear}, {33'h0, 1'b0}, "no clear on B");
    running_counter <= 16'h0300;
    step(2);
    rd_chk(ADDR_FLAG_STATUS, 32'h0D, "compare flags");
    chk({27'h0, irqs}, {27'h0, 7'b0000110}, "compare requests");
    $display("Test compare done");
  endtask

  task automatic t_buffer();
    running_counter <= 16'h3333;
    wr(ADDR_TIMER_CONTROL, 32'h88);
    cap_a_pin <= 1'b0;
    step(2);
    rd_chk(ADDR_CAPTURE_A, 32'h3333, "buffered A value");
    rd_chk(ADDR_CAPTURE_C, 32'h2222, "old A moved to C");
    cap_c_pin <= 1'b1;
    step(2);
    cap_c_pin <= 1'b0;
    step(2);
    rd_chk(ADDR_CAPTURE_C, 32'h2222, "C not captured");
    rd_chk(ADDR_FLAG_STATUS, 32'hAD, "C flag set");
    chk({27'h0, irqs}, {27'h0, 7'b1010110}, "C request");
    $display("Test buffer done");
  endtask

  task automatic t_buffer_b();
    running_counter <= 16'h4444;
    wr(ADDR_TIMER_CONTROL, 32'h44);
    cap_b_pin <= 1'b1;
    step(2);
    rd_chk(ADDR_CAPTURE_B, 32'h4444, "buffered B value");
    rd_chk(ADDR_CAPTURE_D, 32'h2222, "old B moved to D");
    cap_d_pin <= 1'b1;
    step(2);
    cap_d_pin <= 1'b0;
    step(2);
    rd_chk(ADDR_CAPTURE_D, 32'h2222, "D not captured");
    rd_chk(ADDR_FLAG_STATUS, 32'hFD, "B and D flags set");
    chk({27'h0, irqs}, {27'h0, 7'b1111110}, "D request");
    $display("Test buffer B done");
  endtask

  task automatic t_standby();
    standby <= 1'b1;
    step(2);
    standby <= 1'b0;
    rd_chk(ADDR_IRQ_ENABLE, 32'h01, "enable after standby");
    rd_chk(ADDR_FLAG_STATUS, 32'h00, "status after standby");
    rd_chk(ADDR_CAPTURE_A, 32'h0000, "capture after standby");
    chk({27'h0, irqs}, {27'h0, 7'b0000000}, "requests after standby");
    $display("Test standby done");
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    standby = 1'b0;
    counter_tick = 1'b0;
    cap_a_pin = 1'b0;
    cap_b_pin = 1'b0;
    cap_c_pin = 1'b0;
    cap_d_pin = 1'b0;
    running_counter = 16'h0000;
    compare_a_value = 16'h0100;
    compare_b_value = 16'h0200;
    err_total = 0;
    comparisons = 0;
    step(10);
    aresetn <= 1'b1;
    t_regs();
    t_capture();
    t_clear();
    t_compare();
    t_buffer();
    t_buffer_b();
    t_standby();
    finish_test();
  end
endmodule

// ===== verification/tmf_cpu_model.sv
// Register-bus master model for the CPU side of the timer flag block
`timescale 1ns/1ps
module tmf_cpu_model
  import tmf_pkg::*;
(
  input  wire logic              aclk,
  output logic [ADDR_W-1:0]      s_axi_awaddr,
  output logic                   s_axi_awvalid,
  input  wire logic              s_axi_awready,
  output logic [31:0]            s_axi_wdata,
  output logic [3:0]             s_axi_wstrb,
  output logic                   s_axi_wvalid,
  input  wire logic              s_axi_wready,
  input  wire logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_bvalid,
  output logic                   s_axi_bready,
  output logic [ADDR_W-1:0]      s_axi_araddr,
  output logic                   s_axi_arvalid,
  input  wire logic              s_axi_arready,
  input  wire logic [31:0]       s_axi_rdata,
  input  wire logic [1:0]        s_axi_rresp,
  input  wire logic              s_axi_rvalid,
  output logic                   s_axi_rready
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  localparam int LIMIT = 50;
  logic timed_out;

  initial begin
    timed_out     = 1'b0;
    s_axi_awaddr  = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'hF;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
  end

  // Address and data go out together; the slave takes both at one edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                    output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!(s_axi_awready && s_axi_wready) && n < LIMIT);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    while (!s_axi_bvalid && n < LIMIT) begin
      @(posedge aclk);
      n++;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= LIMIT) timed_out = 1'b1;
  endtask

  // Register read; a flag read here as one arms it for a later clearing write
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_arready && n < LIMIT);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid && n < LIMIT) begin
      @(posedge aclk);
      n++;
    end
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= LIMIT) timed_out = 1'b1;
  endtask
endmodule
